/* rtl/prx_pkg.sv */
// Shared constants and types of the pixel-rectangle unpack and index transfer block.
// Assumes a single clock domain and the word-indexed Avalon-MM register map below.
`default_nettype none
package prx_pkg;
  // Fixed-point index layout: integer part above FRAC_W fraction bits.
  localparam int FRAC_W = 8;
  localparam int FX_W   = 32;
  localparam int XY_W   = 16;
  localparam int IDX_W  = 16;
  localparam int TBL_AW = 8;
  // Register word indices on the Avalon address bus.
  localparam logic [3:0] REG_CTRL  = 4'h0;
  localparam logic [3:0] REG_FMT   = 4'h1;
  localparam logic [3:0] REG_SIZE  = 4'h2;
  localparam logic [3:0] REG_BASE  = 4'h3;
  localparam logic [3:0] REG_SHIFT = 4'h4;
  localparam logic [3:0] REG_OFS   = 4'h5;
  localparam logic [3:0] REG_RXY   = 4'h6;
  localparam logic [3:0] REG_RZ    = 4'h7;
  localparam logic [3:0] REG_TEX   = 4'h8;
  localparam logic [3:0] REG_SCLO  = 4'h9;
  localparam logic [3:0] REG_SCHI  = 4'ha;
  localparam logic [3:0] REG_WMASK = 4'hb;
  localparam logic [3:0] REG_TBL   = 4'hc;
  localparam logic [3:0] REG_STAT  = 4'hd;
  // Control register bit positions.
  localparam int CTL_START = 0;
  localparam int CTL_RGBA  = 1;
  localparam int CTL_CMAP  = 2;
  localparam int CTL_SMAP  = 3;
  localparam int CTL_LSB   = 4;
  localparam int CTL_SCIS  = 5;
  // Format register field positions and the reset alignment code (four bytes).
  localparam int FMT_LSB  = 0;
  localparam int TYPE_LSB = 4;
  localparam int ALN_LSB  = 8;
  localparam logic [1:0] ALIGN_RST = 2'h2;
  // Table write register fields: select, entry index, data.
  localparam int TBL_SEL_LSB = 24;
  localparam int TBL_IDX_LSB = 16;
  localparam logic [2:0] TBL_I2I = 3'h0;
  localparam logic [2:0] TBL_S2S = 3'h1;
  localparam logic [2:0] TBL_I2R = 3'h2;
  // Eleven pixel format selections.
  typedef enum logic [3:0] {fmt_color_idx, fmt_stencil_idx, fmt_depth, fmt_rgba, fmt_red, fmt_green,
                            fmt_blue, fmt_alpha, fmt_rgb, fmt_lum, fmt_lum_alpha} prx_fmt_t;
  // Element data types.
  typedef enum logic [2:0] {type_ubyte, type_byte, type_single_bit, type_ushort, type_short,
                            type_uint, type_int, type_float} prx_type_t;
  // Fragment handed to the fragment pipeline.
  typedef struct packed {
    logic [XY_W-1:0]  x;
    logic [XY_W-1:0]  y;
    logic [23:0]      z;
    logic [31:0]      tex;
    logic             is_rgba;
    logic [IDX_W-1:0] idx;
    logic [31:0]      rgba;
  } prx_frag_t;
  // Stencil buffer write.
  typedef struct packed {
    logic [XY_W-1:0]  x;
    logic [XY_W-1:0]  y;
    logic [IDX_W-1:0] val;
    logic [IDX_W-1:0] wmask;
  } prx_stw_t;
endpackage
`default_nettype wire

/* rtl/prx_pixel_rect_unpack.sv */
// Pixel-rectangle write engine: fetches elements, unpacks them and emits fragments or stencil writes.
// Assumes a memory port that answers one word read per request and downstream valid/ready sinks.
`default_nettype none
module prx_pixel_rect_unpack #(
  parameter int CI_BITS = 8,  // Color index buffer width.
  parameter int ST_BITS = 8   // Stencil buffer width.
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic [3:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  output logic                     mem_req,
  output logic      [31:0]         mem_addr,
  input  wire logic                mem_ack,
  input  wire logic [31:0]         mem_rdata,
  output logic                     frag_valid,
  output prx_pkg::prx_frag_t       frag,
  input  wire logic                frag_ready,
  output logic                     st_valid,
  output prx_pkg::prx_stw_t        st,
  input  wire logic                st_ready,
  input  wire logic                pix_owned
);
  localparam int FW = prx_pkg::FX_W;
  localparam int TN = 1 << prx_pkg::TBL_AW;
  localparam logic [prx_pkg::IDX_W-1:0] CI_MASK = prx_pkg::IDX_W'((1 << CI_BITS) - 1);
  localparam logic [prx_pkg::IDX_W-1:0] ST_MASK = prx_pkg::IDX_W'((1 << ST_BITS) - 1);
  // Components that make up one pixel of a format.
  function automatic logic [2:0] ncomp(input prx_pkg::prx_fmt_t f);
    case (f)
      prx_pkg::fmt_lum_alpha: ncomp = 3'h2;
      prx_pkg::fmt_rgb:       ncomp = 3'h3;
      prx_pkg::fmt_rgba:      ncomp = 3'h4;
      default:                ncomp = 3'h1;
    endcase
  endfunction
  // Bytes taken by one element; single bits report one byte but step by bit.
  function automatic logic [31:0] esize(input prx_pkg::prx_type_t t);
    case (t)
      prx_pkg::type_ushort, prx_pkg::type_short: esize = 32'h2;
      prx_pkg::type_uint, prx_pkg::type_int, prx_pkg::type_float: esize = 32'h4;
      default: esize = 32'h1;
    endcase
  endfunction
  // Round a byte address up to the boundary given by a two-bit alignment code.
  function automatic logic [31:0] align_up(input logic [31:0] a, input logic [1:0] code);
    logic [31:0] m;
    m = (32'h1 << code) - 32'h1;
    align_up = (a + m) & ~m;
  endfunction
  // Raw element to fixed point; integers gain a zero fraction, floats keep theirs.
  function automatic logic [FW-1:0] to_fixed(input logic [31:0] r, input prx_pkg::prx_type_t t, input logic b);
    logic [63:0] mag;
    int          e;
    mag = 64'h0;
    e   = 0;
    case (t)
      prx_pkg::type_single_bit: to_fixed = b ? FW'(1 << prx_pkg::FRAC_W) : '0;
      prx_pkg::type_ubyte:      to_fixed = FW'({24'h0, r[7:0]}) << prx_pkg::FRAC_W;
      prx_pkg::type_byte:       to_fixed = FW'({{24{r[7]}}, r[7:0]}) << prx_pkg::FRAC_W;
      prx_pkg::type_ushort:     to_fixed = FW'({16'h0, r[15:0]}) << prx_pkg::FRAC_W;
      prx_pkg::type_short:      to_fixed = FW'({{16{r[15]}}, r[15:0]}) << prx_pkg::FRAC_W;
      prx_pkg::type_float:
      begin
        // Value is mantissa times two to (exponent - 150); scale by the fraction width.
        e = int'(r[30:23]) - 150 + prx_pkg::FRAC_W;
        mag = {40'h0, (r[30:23] != 8'h0), r[22:0]};
        mag = (e >= 0) ? (mag << e) : (mag >> (-e));
        to_fixed = r[31] ? FW'(-mag) : FW'(mag);
      end
      default:                  to_fixed = FW'(r) << prx_pkg::FRAC_W;
    endcase
  endfunction
  typedef enum logic [2:0] {ST_IDLE, ST_REQ, ST_CALC, ST_SEND, ST_STEP} prx_state_t;
  prx_state_t              state_q;     // Fetch and emit sequencer.
  logic                    wait_q;      // Avalon waitrequest, released one cycle after a request.
  logic [31:0]             rdata_q;     // Read data prepared for the releasing edge.
  logic [5:1]              ctrl_q;      // Mode bits from the control register.
  prx_pkg::prx_fmt_t       fmt_q;       // Selected pixel format.
  prx_pkg::prx_type_t      type_q;      // Selected element type.
  logic [1:0]              align_q;     // Row alignment code, log2 of bytes.
  logic [15:0]             width_q;     // Rectangle width in pixels.
  logic [15:0]             height_q;    // Rectangle height in rows.
  logic [31:0]             base_q;      // Start address of pixel data.
  logic signed [5:0]       shift_q;     // Signed index shift amount.
  logic [15:0]             offset_q;    // Signed integer index offset.
  logic [prx_pkg::XY_W-1:0] rx_q, ry_q; // Raster origin.
  logic [23:0]             rz_q;        // Raster depth.
  logic [31:0]             tex_q;       // Raster texture coordinates.
  logic [31:0]             sclo_q;      // Scissor lower corner, y high half.
  logic [31:0]             schi_q;      // Scissor upper corner, inclusive.
  logic [prx_pkg::IDX_W-1:0] wmask_q;  // Stencil write mask passed with each write.
  logic                    busy_q;      // Transfer in progress.
  logic                    err_q;       // Illegal format and type combination seen.
  logic [15:0]             done_q;      // Completed transfers, wraps.
  logic [31:0]             addr_q;      // Byte address of the current element.
  logic [2:0]              bit_q;       // Bit position within a single-bit byte.
  logic [2:0]              comp_q;      // Component within the current pixel.
  logic [15:0]             col_q, row_q;// Pixel column and row.
  logic [31:0]             raw_q;       // Fetched element, shifted to bit 0.
  // Lookup tables, written through the table register.
  logic [prx_pkg::IDX_W-1:0] i2i_mem [TN];
  logic [prx_pkg::IDX_W-1:0] s2s_mem [TN];
  logic [7:0]                i2c_mem [4][TN];
  wire logic wr    = avs_write & ~wait_q;
  wire logic go    = wr && avs_address == prx_pkg::REG_CTRL && avs_writedata[prx_pkg::CTL_START] && !busy_q;
  wire prx_pkg::prx_fmt_t  wfmt  = prx_pkg::prx_fmt_t'(avs_writedata[prx_pkg::FMT_LSB +: 4]);
  wire prx_pkg::prx_type_t wtype = prx_pkg::prx_type_t'(avs_writedata[prx_pkg::TYPE_LSB +: 3]);
  wire logic is_idx  = fmt_q == prx_pkg::fmt_color_idx || fmt_q == prx_pkg::fmt_stencil_idx;
  wire logic is_bit  = type_q == prx_pkg::type_single_bit;
  wire logic bad_cfg = is_bit && !is_idx;
  wire logic pix_end = comp_q == ncomp(fmt_q) - 3'h1;
  wire logic row_end = pix_end && col_q == width_q - 16'h1;
  wire logic last    = row_end && row_q == height_q - 16'h1;
  // Combinational pixel path from the held element.
  logic [2:0]                bsel;
  logic [FW-1:0]             fx, fsh, fsum;
  logic [prx_pkg::TBL_AW-1:0] ti;
  logic [prx_pkg::IDX_W-1:0] ipart, ci_idx, st_val;
  logic [prx_pkg::XY_W-1:0]  px, py;
  logic                      in_sc;
  always_comb
  begin
    bsel   = ctrl_q[prx_pkg::CTL_LSB] ? bit_q : 3'h7 - bit_q;
    fx     = to_fixed(raw_q, type_q, raw_q[bsel]);
    // A logical right shift keeps vacated high bits zero; the left shift below zeroes the vacated low bits.
    fsh    = shift_q[5] ? (fx >> 6'(-shift_q)) : (fx << shift_q);
    fsum   = fsh + (FW'({{16{offset_q[15]}}, offset_q}) << prx_pkg::FRAC_W);
    ti     = fsum[prx_pkg::FRAC_W +: prx_pkg::TBL_AW];
    ipart  = fsum[prx_pkg::FRAC_W +: prx_pkg::IDX_W];
    ci_idx = (ctrl_q[prx_pkg::CTL_CMAP] ? i2i_mem[ti] : ipart) & CI_MASK;
    st_val = (ctrl_q[prx_pkg::CTL_SMAP] ? s2s_mem[ti] : ipart) & ST_MASK;
    px     = rx_q + col_q;
    py     = ry_q + row_q;
    in_sc  = !ctrl_q[prx_pkg::CTL_SCIS] || (px >= sclo_q[15:0] && px <= schi_q[15:0]
             && py >= sclo_q[31:16] && py <= schi_q[31:16]);
  end

  // Avalon slave handshake: every access waits exactly one cycle, then completes.
  always_ff @(posedge clk)
  begin
    if (rst)
      wait_q <= 1'b1;
    else if ((avs_read | avs_write) && wait_q)
      wait_q <= 1'b0;
    else
      wait_q <= 1'b1;
  end

  // Read data is captured while waitrequest is still high so it stands at the release edge.
  always_ff @(posedge clk)
  begin
    if (rst)
      rdata_q <= '0;
    else if (avs_read && wait_q)
    begin
      case (avs_address)
        prx_pkg::REG_CTRL:  rdata_q <= {26'h0, ctrl_q, 1'b0};
        prx_pkg::REG_FMT:   rdata_q <= {22'h0, align_q, 1'b0, type_q, fmt_q};
        prx_pkg::REG_SIZE:  rdata_q <= {height_q, width_q};
        prx_pkg::REG_BASE:  rdata_q <= base_q;
        prx_pkg::REG_SHIFT: rdata_q <= 32'(shift_q);
        prx_pkg::REG_OFS:   rdata_q <= {16'h0, offset_q};
        prx_pkg::REG_RXY:   rdata_q <= {ry_q, rx_q};
        prx_pkg::REG_RZ:    rdata_q <= {8'h0, rz_q};
        prx_pkg::REG_TEX:   rdata_q <= tex_q;
        prx_pkg::REG_SCLO:  rdata_q <= sclo_q;
        prx_pkg::REG_SCHI:  rdata_q <= schi_q;
        prx_pkg::REG_WMASK: rdata_q <= {16'h0, wmask_q};
        prx_pkg::REG_STAT:  rdata_q <= {done_q, 14'h0, err_q, busy_q};
        // Unmapped and write-only addresses read as zero.
        default:            rdata_q <= '0;
      endcase
    end
  end

  // Configuration registers; writes land while busy too, so software must wait for idle.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_q <= '0;
      fmt_q <= prx_pkg::fmt_color_idx;
      type_q <= prx_pkg::type_ubyte;
      align_q <= prx_pkg::ALIGN_RST;
      {width_q, height_q, base_q, shift_q, offset_q} <= '0;
      {rx_q, ry_q, rz_q, tex_q, sclo_q, schi_q, wmask_q} <= '0;
    end
    else if (wr)
    begin
      case (avs_address)
        prx_pkg::REG_CTRL:  ctrl_q <= avs_writedata[5:1];
        prx_pkg::REG_FMT:
        begin
          // Codes past the eleventh format fall back to color index.
          fmt_q   <= (avs_writedata[prx_pkg::FMT_LSB +: 4] > 4'ha) ? prx_pkg::fmt_color_idx : wfmt;
          type_q  <= wtype;
          align_q <= avs_writedata[prx_pkg::ALN_LSB +: 2];
        end
        prx_pkg::REG_SIZE:  {height_q, width_q} <= avs_writedata;
        prx_pkg::REG_BASE:  base_q <= avs_writedata;
        prx_pkg::REG_SHIFT: shift_q <= avs_writedata[5:0];
        prx_pkg::REG_OFS:   offset_q <= avs_writedata[15:0];
        prx_pkg::REG_RXY:   {ry_q, rx_q} <= avs_writedata;
        prx_pkg::REG_RZ:    rz_q <= avs_writedata[23:0];
        prx_pkg::REG_TEX:   tex_q <= avs_writedata;
        prx_pkg::REG_SCLO:  sclo_q <= avs_writedata;
        prx_pkg::REG_SCHI:  schi_q <= avs_writedata;
        prx_pkg::REG_WMASK: wmask_q <= avs_writedata[15:0];
        default:            ;
      endcase
    end
  end

  // Table writes; tables are not reset and must be loaded before mapping is enabled.
  always_ff @(posedge clk)
  begin
    if (wr && avs_address == prx_pkg::REG_TBL)
    begin
      case (avs_writedata[prx_pkg::TBL_SEL_LSB +: 3])
        prx_pkg::TBL_I2I: i2i_mem[avs_writedata[prx_pkg::TBL_IDX_LSB +: 8]] <= avs_writedata[15:0];
        prx_pkg::TBL_S2S: s2s_mem[avs_writedata[prx_pkg::TBL_IDX_LSB +: 8]] <= avs_writedata[15:0];
        default:
        begin
          // Selects past the alpha table are ignored rather than folded onto the red or green table.
          if (avs_writedata[prx_pkg::TBL_SEL_LSB +: 3] >= prx_pkg::TBL_I2R
              && 32'(avs_writedata[prx_pkg::TBL_SEL_LSB +: 3] - prx_pkg::TBL_I2R) < $size(i2c_mem, 1))
            i2c_mem[2'(avs_writedata[prx_pkg::TBL_SEL_LSB +: 3] - prx_pkg::TBL_I2R)]
                   [avs_writedata[prx_pkg::TBL_IDX_LSB +: 8]] <= avs_writedata[7:0];
        end
      endcase
    end
  end

  // Error flag: a single-bit type with a non-index format refuses the start; cleared by a legal start.
  always_ff @(posedge clk)
  begin
    if (rst)
      err_q <= 1'b0;
    else if (go)
      err_q <= bad_cfg;
  end

  // Sequencer: fetch, convert, emit, advance, strictly in row-major order.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      {busy_q, mem_req, mem_addr, addr_q, bit_q, comp_q, col_q, row_q, raw_q, done_q} <= '0;
      {frag_valid, frag, st_valid, st} <= '0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          // Empty rectangles and illegal combinations never start a fetch.
          if (go && !bad_cfg && width_q != 16'h0 && height_q != 16'h0)
          begin
            busy_q <= 1'b1;
            addr_q <= base_q;
            {bit_q, comp_q, col_q, row_q} <= '0;
            state_q <= ST_REQ;
          end
        end
        ST_REQ:
        begin
          mem_req  <= !mem_ack;
          mem_addr <= {addr_q[31:2], 2'b00};
          if (mem_req && mem_ack)
          begin
            raw_q <= mem_rdata >> {addr_q[1:0], 3'b000};
            state_q <= ST_CALC;
          end
        end
        ST_CALC:
        begin
          // Only the end of an index pixel produces output; color groups are consumed here.
          if (!is_idx || !pix_end)
            state_q <= ST_STEP;
          else if (fmt_q == prx_pkg::fmt_stencil_idx)
          begin
            st.x <= px;
            st.y <= py;
            st.val <= st_val;
            st.wmask <= wmask_q;
            st_valid <= in_sc && pix_owned;
            state_q <= (in_sc && pix_owned) ? ST_SEND : ST_STEP;
          end
          else
          begin
            // Fragment carries raster depth and texture and goes on to the full pipeline.
            frag.x <= px;
            frag.y <= py;
            frag.z <= rz_q;
            frag.tex <= tex_q;
            frag.is_rgba <= ctrl_q[prx_pkg::CTL_RGBA];
            frag.idx <= ctrl_q[prx_pkg::CTL_RGBA] ? ipart : ci_idx;
            frag.rgba <= {i2c_mem[0][ti], i2c_mem[1][ti], i2c_mem[2][ti], i2c_mem[3][ti]};
            frag_valid <= 1'b1;
            state_q <= ST_SEND;
          end
        end
        ST_SEND:
        begin
          // Output holds steady until taken, so a stall loses nothing.
          if ((frag_valid && frag_ready) || (st_valid && st_ready))
          begin
            frag_valid <= 1'b0;
            st_valid <= 1'b0;
            state_q <= ST_STEP;
          end
        end
        ST_STEP:
        begin
          comp_q <= pix_end ? 3'h0 : comp_q + 3'h1;
          if (row_end)
          begin
            // Partly used bytes of single-bit data are skipped before aligning.
            addr_q <= align_up(addr_q + esize(type_q), align_q);
            bit_q <= 3'h0;
            col_q <= 16'h0;
            row_q <= row_q + 16'h1;
          end
          else
          begin
            if (!is_bit || bit_q == 3'h7)
              addr_q <= addr_q + esize(type_q);
            if (is_bit)
              bit_q <= bit_q + 3'h1;
            if (pix_end)
              col_q <= col_q + 16'h1;
          end
          busy_q <= !last;
          done_q <= last ? done_q + 16'h1 : done_q;
          state_q <= last ? ST_IDLE : ST_REQ;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata    = rdata_q;

  // Checks on the block's outputs and internal state.
  frag_hold_a: assert property (@(posedge clk) disable iff (rst)
    frag_valid && !frag_ready |=> frag_valid && $stable(frag)) else $error("fragment dropped while stalled");
  st_hold_a: assert property (@(posedge clk) disable iff (rst)
    st_valid && !st_ready |=> st_valid && $stable(st)) else $error("stencil write dropped while stalled");
  ci_mask_a: assert property (@(posedge clk) disable iff (rst)
    frag_valid && !frag.is_rgba |-> (frag.idx & ~CI_MASK) == '0) else $error("color index not masked");
  st_mask_a: assert property (@(posedge clk) disable iff (rst)
    st_valid |-> (st.val & ~ST_MASK) == '0) else $error("stencil value not masked");
  st_scissor_a: assert property (@(posedge clk) disable iff (rst)
    st_valid && ctrl_q[prx_pkg::CTL_SCIS] |-> st.x >= sclo_q[15:0] && st.x <= schi_q[15:0])
    else $error("stencil write outside scissor");
  bit_fmt_a: assert property (@(posedge clk) disable iff (rst)
    busy_q && is_bit |-> is_idx) else $error("single-bit run with color format");
  row_align_a: assert property (@(posedge clk) disable iff (rst)
    state_q == ST_STEP && row_end && !last |=> (addr_q & ((32'h1 << align_q) - 32'h1)) == '0)
    else $error("row start not aligned");
  frag_pos_a: assert property (@(posedge clk) disable iff (rst)
    $rose(frag_valid) |-> frag.x == rx_q + col_q && frag.y == ry_q + row_q) else $error("fragment position wrong");
  bit_value_a: assert property (@(posedge clk) disable iff (rst)
    state_q == ST_CALC && is_bit |-> fx == '0 || fx == FW'(1 << prx_pkg::FRAC_W)) else $error("bit not 0.0 or 1.0");
  frag_stall_c: cover property (@(posedge clk) disable iff (rst) frag_valid && !frag_ready ##1 frag_ready);
  st_write_c: cover property (@(posedge clk) disable iff (rst) st_valid && st_ready);
  row_wrap_c: cover property (@(posedge clk) disable iff (rst) state_q == ST_STEP && row_end && !last);
endmodule
`default_nettype wire

/* test/prx_mem_model.sv */
// Memory source model answering element fetches with address-derived bytes.
// Assumes the engine holds mem_req and mem_addr until it sees mem_ack.
`default_nettype none
module prx_mem_model (
  input  wire logic        clk,
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  output logic             mem_ack = 1'b0,
  output logic      [31:0] mem_rdata = 32'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_q = 2'h0;  // Stall counter, so answers come slowly.
  logic       hit;            // This cycle's request gets its answer.
  assign hit = mem_req && !mem_ack && wait_q == 2'h3;
  // Byte k of a word is (address + k) xor 5a; rdata is scrambled off the ack cycle.
  always_ff @(posedge clk)
  begin
    wait_q <= wait_q + 2'h1;
    mem_ack <= hit;
    mem_rdata <= hit ? {mem_addr[7:0] + 8'h3, mem_addr[7:0] + 8'h2, mem_addr[7:0] + 8'h1,
                        mem_addr[7:0]} ^ 32'h5a5a5a5a : ~mem_rdata;
  end
endmodule
`default_nettype wire

/* test/tb.sv */
// Self-checking bench: index and stencil rectangles at two row alignments, then one single-bit run.
// Assumes the engine and the memory model; pixels are always owned.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, rd, wr, wreq, mreq, mack, fv, frd, sv, srd;
  logic [3:0]  adr;
  logic [31:0] wd, rdat, maddr, mrd;
  logic [31:0] seed = 32'hbf6126f1;  // Xorshift state for stalls and offsets.
  prx_pkg::prx_frag_t frag;
  prx_pkg::prx_stw_t  st;
  int num_errors = 0;
  int checks = 0;
  logic [103:0] exp_q[$];  // Expected x, y, value, depth or write mask, texture, in row-major order.
  prx_pixel_rect_unpack i_prx_pixel_rect_unpack (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wreq), .mem_req(mreq),
    .mem_addr(maddr), .mem_ack(mack), .mem_rdata(mrd), .frag_valid(fv), .frag(frag), .frag_ready(frd),
    .st_valid(sv), .st(st), .st_ready(srd), .pix_owned(1'b1));
  prx_mem_model i_prx_mem_model (.clk(clk), .mem_req(mreq), .mem_addr(maddr), .mem_ack(mack), .mem_rdata(mrd));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Next state of the xorshift generator that feeds stalls and offsets.
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xorshift = t ^ (t << 5);
  endfunction
  // One Avalon access; the request stands until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %0t register read %h", $time, got);
    end
  endtask
  // Each accepted pixel is matched against the oldest note.
  task automatic cmp_pix(input logic [103:0] got);
    checks++;
    if (exp_q.size() == 0 || got !== exp_q.pop_front())
    begin
      num_errors++;
      $display("unexpected %0t pixel %h", $time, got);
    end
  endtask
  task automatic finish_test;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Random stalls on both sinks check that no pixel is lost while held.
  always @(posedge clk)
  begin
    seed <= xorshift(seed);
    frd <= seed[0];
    srd <= seed[1];
    if (!rst && fv === 1'b1 && frd === 1'b1)
      cmp_pix({frag.x, frag.y, frag.idx, frag.z, frag.tex});
    if (!rst && sv === 1'b1 && srd === 1'b1)
      cmp_pix({st.x, st.y, st.val, 8'h00, st.wmask, 32'h0});
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    finish_test();
  end
  initial
  begin
    logic [31:0] q;
    logic [7:0]  e;
    logic [1:0]  al;
    logic [15:0] ofs;
    logic        bm;
    int          stride;
    {rst, rd, wr, adr, wd} = {3'h4, 4'h0, 32'h0};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, prx_pkg::REG_FMT, 32'h0, q);
    cmp_reg(q, 32'h00000200);
    bus(1'b0, 4'he, 32'h0, q);
    cmp_reg(q, 32'h0);
    // A format code past the eleventh reads back as color index.
    bus(1'b1, prx_pkg::REG_FMT, 32'h0000000f, q);
    bus(1'b0, prx_pkg::REG_FMT, 32'h0, q);
    cmp_reg(q, 32'h0);
    // Depth, texture and write mask ride along unchanged; the scissor passes columns 16 and 17 only.
    bus(1'b1, prx_pkg::REG_RZ, 32'h00123456, q);
    bus(1'b1, prx_pkg::REG_TEX, 32'h89abcdef, q);
    bus(1'b1, prx_pkg::REG_WMASK, 32'h000000f0, q);
    bus(1'b1, prx_pkg::REG_SCLO, 32'h00000010, q);
    bus(1'b1, prx_pkg::REG_SCHI, 32'hffff0011, q);
    // Index table entry 0 carries a bit above the eight-bit index buffer, so the mask must drop it.
    bus(1'b1, prx_pkg::REG_TBL, 32'h00000133, q);
    bus(1'b1, prx_pkg::REG_TBL, 32'h000100c6, q);
    // Three by two rectangles; one- and eight-byte rows pad differently; the last run is single bits.
    for (int i = 0; i < 5; i++)
    begin
      bm = i == 4;
      al = i[1] ? 2'h3 : 2'h0;
      stride = ((3 + (1 << al) - 1) >> al) << al;
      ofs = bm ? 16'h0 : {8'h00, seed[7:0]};
      for (int n = 0; n < 6; n++)
      begin
        e = 8'(32'h40 + (n / 3) * (bm ? 1 : stride) + (bm ? 0 : n % 3)) ^ 8'h5a;
        if (bm)
          exp_q.push_back({16'(16 + n % 3), 16'(32 + n / 3), 8'h00, e[n % 3] ? 8'hc6 : 8'h33,
                           24'h123456, 32'h89abcdef});
        else if (i != 3 || n % 3 != 2)
          exp_q.push_back({16'(16 + n % 3), 16'(32 + n / 3), 8'h00, 8'(2 * e + ofs),
                           i[0] ? 56'h0000f000000000 : 56'h12345689abcdef});
      end
      bus(1'b1, prx_pkg::REG_FMT, {22'h0, al, 2'h0, bm, 4'h0, i[0]}, q);
      bus(1'b1, prx_pkg::REG_SIZE, 32'h00020003, q);
      bus(1'b1, prx_pkg::REG_BASE, 32'h40, q);
      bus(1'b1, prx_pkg::REG_SHIFT, {31'h0, !bm}, q);
      bus(1'b1, prx_pkg::REG_OFS, {16'h0, ofs}, q);
      bus(1'b1, prx_pkg::REG_RXY, 32'h00200010, q);
      bus(1'b1, prx_pkg::REG_CTRL, {26'h0, i == 3, bm, 1'b0, bm, 2'h1}, q);
      do bus(1'b0, prx_pkg::REG_STAT, 32'h0, q); while (q[0] !== 1'b0 || exp_q.size() != 0);
    end
    finish_test();
  end
endmodule
`default_nettype wire
